// ==== design/arcl_compare.sv ====
// Compare unit that decides whether a conversion result is stored
`timescale 1ns/100ps
`default_nettype none
module arcl_compare
(
    input wire logic enable,
    input wire logic ge_select,
    input wire logic [9:0] raw,
    input wire logic [9:0] level,
    output logic hit,
    output logic [9:0] processed
);
    logic below;

    // ------------------------------------------------------------
    // Compare sense and result forming
    // ------------------------------------------------------------
    // Raw value below the level
    assign below = (raw < level);

    assign hit = enable ? (ge_select ? ~below : below) : 1'b1;

    assign processed = enable ? (raw - level) : raw;
endmodule : arcl_compare
`default_nettype wire

// ==== design/arcl_pkg.sv ====
// Package for the converter result and compare logic
package arcl_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS_CONTROL_TWO = 8'h00;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h0c;
    localparam logic [7:0] ADDR_COMPARE_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int CMP_ENABLE_BIT = 5;
    localparam int CMP_GE_BIT = 4;
    localparam int RESULT_WIDTH = 10;
    localparam int BYTE_WIDTH = 8;
    localparam int HIGH_BITS = 2;
    localparam int MODE_BIT = 0;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_DISCARD_BIT = 1;
    localparam int STAT_VALID_BIT = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [9:0] RESET_LEVEL = 10'h000;

    // Resolution modes
    typedef enum logic [0:0] {
        ARCL_MODE_8BIT = 1'b0,
        ARCL_MODE_10BIT = 1'b1
    } arcl_mode_t;

    // Conversion-done strobe together with its raw word
    typedef struct packed {
        logic done;
        logic [9:0] data;
    } arcl_conv_t;

    // Read-order interlock states
    typedef enum logic {
        ARCL_OPEN,
        ARCL_HELD
    } arcl_lock_t;
endpackage : arcl_pkg

// ==== design/arcl_top.sv ====
// Converter result registers, automatic compare and read interlock
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module arcl_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire arcl_pkg::arcl_conv_t conv
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_two;
    logic [7:0] next_ctrl_two;
    logic [7:0] result_high;
    logic [7:0] next_result_high;
    logic [7:0] result_low;
    logic [7:0] next_result_low;
    arcl_pkg::arcl_mode_t mode;
    arcl_pkg::arcl_mode_t next_mode;
    logic [9:0] cmp_level;
    logic [9:0] next_cmp_level;
    arcl_pkg::arcl_lock_t lock;
    arcl_pkg::arcl_lock_t next_lock;
    logic discarded;
    logic next_discarded;
    logic high_valid;
    logic next_high_valid;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic cmp_hit;
    logic [9:0] cmp_value;
    logic access;
    logic wr;
    logic rd;

    // Address decode shared by read and write
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == arcl_pkg::ADDR_STATUS_CONTROL_TWO) ||
                    (a == arcl_pkg::ADDR_RESULT_HIGH) ||
                    (a == arcl_pkg::ADDR_RESULT_LOW) ||
                    (a == arcl_pkg::ADDR_MODE) ||
                    (a == arcl_pkg::ADDR_COMPARE_LEVEL) ||
                    (a == arcl_pkg::ADDR_STATUS);
    endfunction : is_mapped

    // ------------------------------------------------------------
    // Compare unit
    // ------------------------------------------------------------
    arcl_compare u_compare
    (
        .enable(ctrl_two[arcl_pkg::CMP_ENABLE_BIT]),
        .ge_select(ctrl_two[arcl_pkg::CMP_GE_BIT]),
        .raw(conv.data),
        .level(cmp_level),
        .hit(cmp_hit),
        .processed(cmp_value)
    );

    // Access phase strobes; slave answers in the second access cycle, one wait state
    assign access = psel && penable && !pready;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;

    // ------------------------------------------------------------
    // Next-state logic for registers, results and interlock
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctrl_two = ctrl_two;
        next_mode = mode;
        next_cmp_level = cmp_level;
        next_result_high = result_high;
        next_result_low = result_low;
        next_lock = lock;
        next_discarded = discarded;
        next_high_valid = high_valid;
        next_prdata = 32'h0000_0000;
        next_pready = access;
        next_pslverr = access && !is_mapped(paddr);

        // Software writes
        if (wr)
        begin
            case (paddr)
                arcl_pkg::ADDR_STATUS_CONTROL_TWO:
                    next_ctrl_two = pwdata[7:0];
                arcl_pkg::ADDR_MODE:
                begin
                    next_mode = arcl_pkg::arcl_mode_t'(pwdata[arcl_pkg::MODE_BIT]);
                    if (next_mode != mode)
                    begin
                        next_high_valid = 1'b0;
                        next_lock = arcl_pkg::ARCL_OPEN;
                    end
                end
                arcl_pkg::ADDR_COMPARE_LEVEL:
                    next_cmp_level = pwdata[9:0];
                arcl_pkg::ADDR_STATUS:
                    // Write one clears the discard flag
                    if (pwdata[arcl_pkg::STAT_DISCARD_BIT])
                        next_discarded = 1'b0;
                default:
                    next_ctrl_two = ctrl_two;
            endcase
        end

        // Software reads and their interlock effects
        if (rd)
        begin
            case (paddr)
                arcl_pkg::ADDR_STATUS_CONTROL_TWO:
                    next_prdata = {24'h00_0000, ctrl_two};
                arcl_pkg::ADDR_RESULT_HIGH:
                begin
                    next_prdata = {24'h00_0000, result_high};
                    // high read arms interlock in 10-bit mode
                    if (mode == arcl_pkg::ARCL_MODE_10BIT)
                        next_lock = arcl_pkg::ARCL_HELD;
                end
                arcl_pkg::ADDR_RESULT_LOW:
                begin
                    next_prdata = {24'h00_0000, result_low};
                    next_lock = arcl_pkg::ARCL_OPEN;
                end
                arcl_pkg::ADDR_MODE:
                    next_prdata = {31'h0000_0000, mode};
                arcl_pkg::ADDR_COMPARE_LEVEL:
                    next_prdata = {22'h00_0000, cmp_level};
                arcl_pkg::ADDR_STATUS:
                    next_prdata = {29'h0000_0000, high_valid, discarded,
                                   lock == arcl_pkg::ARCL_HELD};
                default:
                    next_prdata = 32'h0000_0000;
            endcase
        end

        if (conv.done)
        begin
            if (lock == arcl_pkg::ARCL_HELD)
            begin
                // result lost while interlock holds; set wins over clear
                next_discarded = 1'b1;
            end
            // load unless compare on and unmet
            else if (cmp_hit)
            begin
                next_high_valid = 1'b1;
                if (next_mode == arcl_pkg::ARCL_MODE_10BIT)
                begin
                    // top two bits only; processed value
                    next_result_high = {6'h00, cmp_value[9:8]};
                    next_result_low = cmp_value[7:0];
                end
                else
                begin
                    next_result_high = arcl_pkg::RESET_BYTE;
                    // whole 8-bit result from the top bits
                    next_result_low = cmp_value[9:2];
                end
            end
        end
        if (wr && paddr == arcl_pkg::ADDR_MODE &&
            next_mode == arcl_pkg::ARCL_MODE_8BIT)
        begin
            // entering 8-bit mode clears high bits
            next_result_high = arcl_pkg::RESET_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_two <= arcl_pkg::RESET_BYTE;
            mode <= arcl_pkg::ARCL_MODE_8BIT;
            cmp_level <= arcl_pkg::RESET_LEVEL;
            result_high <= arcl_pkg::RESET_BYTE;
            result_low <= arcl_pkg::RESET_BYTE;
            lock <= arcl_pkg::ARCL_OPEN;
            discarded <= 1'b0;
            high_valid <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_two <= next_ctrl_two;
            mode <= next_mode;
            cmp_level <= next_cmp_level;
            result_high <= next_result_high;
            result_low <= next_result_low;
            lock <= next_lock;
            discarded <= next_discarded;
            high_valid <= next_high_valid;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule : arcl_top
`default_nettype wire

// ==== tb/adc_result_compare_logic_tb_top.sv ====
// Testbench for the converter result and compare logic
`timescale 1ns/100ps
`default_nettype none
module adc_result_compare_logic_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic start = 1'b0, pready, pslverr, slv;
    logic [7:0] paddr = 8'h00;
    logic [9:0] value = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    arcl_pkg::arcl_conv_t conv;
    int err_total = 0, check_count = 0;
    always #12.5 pclk = ~pclk;
    arcl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv(conv));
    arcl_core_model core (.pclk(pclk), .presetn(presetn), .start(start), .value(value),
        .conv(conv));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1)
            err_total++;
        {rd, slv} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic convert(input logic [9:0] v);
        int n = 0;
        {start, value} <= {1'b1, v};
        @(posedge pclk);
        start <= 1'b0;
        do @(posedge pclk); while (conv.done !== 1'b1 && ++n < 20);
        if (conv.done !== 1'b1)
            err_total++;
        @(posedge pclk);
    endtask : convert
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    // Watchdog cuts a hang short
    initial
    begin
        #100000;
        err_total++;
        finish_test();
    end
    // Reset, ten-bit loads, interlock, compare, short mode
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(arcl_pkg::ADDR_STATUS_CONTROL_TWO, 32'h0);
        apb(1'b1, arcl_pkg::ADDR_MODE, 32'h1);
        convert(10'h2a5);
        rchk(arcl_pkg::ADDR_RESULT_HIGH, 32'h2);
        rchk(arcl_pkg::ADDR_STATUS, 32'h5);
        convert(10'h155);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'ha5);
        convert(10'h155);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'h55);
        apb(1'b1, arcl_pkg::ADDR_STATUS, 32'h2);
        rchk(arcl_pkg::ADDR_STATUS, 32'h4);
        $display("test interlock done");
        apb(1'b1, arcl_pkg::ADDR_COMPARE_LEVEL, 32'h100);
        apb(1'b1, arcl_pkg::ADDR_STATUS_CONTROL_TWO, 32'h20);
        convert(10'h300);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'h55);
        convert(10'h080);
        rchk(arcl_pkg::ADDR_RESULT_HIGH, 32'h3);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'h80);
        apb(1'b1, arcl_pkg::ADDR_STATUS_CONTROL_TWO, 32'h30);
        rchk(arcl_pkg::ADDR_STATUS_CONTROL_TWO, 32'h30);
        convert(10'h050);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'h80);
        convert(10'h1ff);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'hff);
        $display("test compare done");
        apb(1'b1, arcl_pkg::ADDR_STATUS_CONTROL_TWO, 32'h0);
        apb(1'b1, arcl_pkg::ADDR_MODE, 32'h0);
        rchk(arcl_pkg::ADDR_STATUS, 32'h0);
        convert(10'h2a5);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'ha9);
        rchk(arcl_pkg::ADDR_RESULT_HIGH, 32'h0);
        convert(10'h3fc);
        rchk(arcl_pkg::ADDR_RESULT_LOW, 32'hff);
        rchk(arcl_pkg::ADDR_STATUS, 32'h4);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, slv}, 32'h1);
        $display("test short mode done");
        finish_test();
    end
endmodule : adc_result_compare_logic_tb_top
`default_nettype wire

// ==== tb/arcl_chk.sv ====
// Checker for result registers, compare control and read interlock
`timescale 1ns/100ps
`default_nettype none
module arcl_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire arcl_pkg::arcl_conv_t conv
);
    logic wr, rd, rd_hi, rd_lo, rd_st, mode_h, lock_h, seen_h, prev_h;
    logic [7:0] ctrl_h, low_h;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accesses completed at this edge
    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    assign rd_hi = rd && paddr == arcl_pkg::ADDR_RESULT_HIGH;
    assign rd_lo = rd && paddr == arcl_pkg::ADDR_RESULT_LOW;
    assign rd_st = rd && paddr == arcl_pkg::ADDR_STATUS;
    // Shadow of control, mode, interlock and last low byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {mode_h, lock_h, seen_h, prev_h, ctrl_h, low_h} <= '0;
        else
        begin
            if (wr && paddr == arcl_pkg::ADDR_STATUS_CONTROL_TWO)
                ctrl_h <= pwdata[7:0];
            if (wr && paddr == arcl_pkg::ADDR_MODE)
                mode_h <= pwdata[0];
            if (conv.done && !lock_h)
                seen_h <= 1'b1;
            if (rd_hi && mode_h)
                lock_h <= 1'b1;
            if (rd_lo || (wr && paddr == arcl_pkg::ADDR_MODE))
                lock_h <= 1'b0;
            if (rd_lo)
                {seen_h, prev_h, low_h} <= {2'b01, prdata[7:0]};
        end
    end
    a_enable_readback: assert property (rd && paddr == 8'h00 |-> prdata[5] == ctrl_h[5])
        else $error("compare enable bit differs");
    a_sense_readback: assert property (rd && paddr == 8'h00 |-> prdata[4] == ctrl_h[4])
        else $error("compare sense bit differs");
    a_high_two_bits: assert property (rd_hi && mode_h |-> prdata[31:2] == 30'h0)
        else $error("high result wider than two bits");
    a_low_one_byte: assert property (rd_lo |-> prdata[31:8] == 24'h0)
        else $error("low result wider than a byte");
    a_high_eight_zero: assert property (rd_hi && !mode_h |-> prdata == 32'h0)
        else $error("high result not zero in short mode");
    a_lock_status: assert property (rd_st && mode_h |-> prdata[0] == lock_h)
        else $error("interlock state differs");
    a_no_lock_eight: assert property (rd_st && !mode_h |-> !prdata[0])
        else $error("interlock held in short mode");
    a_held_discard: assert property (rd_lo && prev_h && !seen_h |-> prdata[7:0] == low_h)
        else $error("low result changed without a stored load");
endmodule : arcl_chk
bind arcl_top arcl_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv(conv));
`default_nettype wire

// ==== tb/arcl_core_model.sv ====
// Model of the converter core delivering finished results
`timescale 1ns/100ps
`default_nettype none
module arcl_core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [9:0] value,
    output var arcl_pkg::arcl_conv_t conv
);
    int count;
    logic [9:0] held;
    // Count a conversion down, then strobe done once with its word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {count, held, conv} <= '0;
        else
        begin
            conv.done <= (count == 1);
            conv.data <= (count == 1) ? held : ~conv.data;
            if (start)
                {count, held} <= {32'd3, value};
            else if (count > 0)
                count <= count - 1;
        end
    end
endmodule : arcl_core_model
`default_nettype wire
